// ==== dv/qsf_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsf_load_model
   import qsf_pkg::*;
(
   input  wire logic [NCH-1:0] gate_on,
   input  wire logic [NCH-1:0] short_ld,
   input  wire logic [NCH-1:0] open_ld,
   input  wire logic [NCH-1:0] soft_ld,
   output var  qsf_sense_t     sense
);
   // a short lifts the drain above threshold only while driven
   // a soft open starves on current but does not pull the drain when off
   always_comb begin
      sense.oc_detect = short_ld & gate_on;
      sense.on_open   = (open_ld | soft_ld) & gate_on;
      sense.off_open  = open_ld;
   end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import qsf_pkg::*;
   logic           sys_clk = 1'b0;
   logic           resetn = 1'b0;
   logic [NCH-1:0] in_single = '0;
   logic [1:0]     in_pair = '0;
   logic           dual_mode = 1'b0;
   logic [NCH-1:0] short_ld = '0;
   logic [NCH-1:0] open_ld = '0;
   logic [NCH-1:0] soft_ld = '0;
   qsf_sense_t     sense;
   logic [NCH-1:0] gate_on;
   logic           fault_n;
   int             n_errors = 0;
   int             checks_done = 0;

   always #2.5 sys_clk = ~sys_clk;

   qsf_supervisor i_dut (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_single (in_single),
      .in_pair   (in_pair),
      .dual_mode (dual_mode),
      .sense     (sense),
      .gate_on   (gate_on),
      .fault_n   (fault_n)
   );

   qsf_load_model i_load (
      .gate_on  (gate_on),
      .short_ld (short_ld),
      .open_ld  (open_ld),
      .soft_ld  (soft_ld),
      .sense    (sense)
   );

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // every wait ends just after an edge, so drives land off the edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wait_us(input int n);
      wait_cyc(n * TICK_CYC);
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic t_follow();
      in_single = 4'hF;
      wait_cyc(10);
      check(gate_on, 4'hF);
      check({3'h0, fault_n}, 4'h1);
      in_single = 4'h0;
      wait_cyc(10);
      check(gate_on, 4'h0);
      $display("test follow done");
   endtask

   task automatic t_blank();
      // ch0 shorted but off, ch1 inrush clears inside the sense time
      in_single = 4'h2;
      short_ld = 4'h3;
      wait_us(30);
      short_ld = 4'h0;
      wait_us(40);
      check({3'h0, fault_n}, 4'h1);
      check(gate_on, 4'h2);
      in_single = 4'h0;
      $display("test blank done");
   endtask

   task automatic t_trip();
      in_single = 4'hF;
      short_ld = 4'h4;
      wait_us(40);
      in_single = 4'hB;
      wait_us(2);
      in_single = 4'hF;
      wait_us(45);
      check({3'h0, fault_n}, 4'h1);
      wait_us(15);
      check({3'h0, fault_n}, 4'h0);
      check(gate_on, 4'hB);
      wait_us(10);
      check(gate_on, 4'hB);
      in_single = 4'h0;
      wait_us(10);
      check({3'h0, fault_n}, 4'h0);
      wait_us(15);
      check({3'h0, fault_n}, 4'h1);
      in_single = 4'h1;
      wait_us(60);
      check({3'h0, fault_n}, 4'h1);
      in_single = 4'h0;
      wait_us(2);
      in_single = 4'h4;
      wait_us(2);
      check(gate_on, 4'h4);
      wait_us(58);
      check({3'h0, fault_n}, 4'h0);
      in_single = 4'h0;
      short_ld = 4'h0;
      wait_us(30);
      check({3'h0, fault_n}, 4'h1);
      $display("test trip done");
   endtask

   task automatic t_open();
      // one faulted channel at a time keeps the status readable
      in_single = 4'h8;
      open_ld = 4'h8;
      wait_us(15);
      in_single = 4'h9;
      wait_us(15);
      check({3'h0, fault_n}, 4'h1);
      wait_us(10);
      check({3'h0, fault_n}, 4'h0);
      in_single = 4'h1;
      wait_us(5);
      check({3'h0, fault_n}, 4'h1);
      in_single = 4'h0;
      wait_us(10);
      check({3'h0, fault_n}, 4'h1);
      wait_us(15);
      check({3'h0, fault_n}, 4'h0);
      open_ld = 4'h0;
      wait_us(5);
      check({3'h0, fault_n}, 4'h1);
      // soft open must not report once the short on-mask lapses
      soft_ld = 4'h2;
      in_single = 4'h2;
      wait_us(30);
      check({3'h0, fault_n}, 4'h1);
      check(gate_on, 4'h2);
      in_single = 4'h0;
      soft_ld = 4'h0;
      $display("test open done");
   endtask

   task automatic t_dual();
      // host resolves only to the pair it drives
      dual_mode = 1'b1;
      in_single = 4'hF;
      in_pair = 2'b01;
      wait_cyc(10);
      check(gate_on, 4'h3);
      in_pair = 2'b10;
      wait_cyc(10);
      check(gate_on, 4'hC);
      in_pair = 2'b00;
      wait_cyc(10);
      check(gate_on, 4'h0);
      dual_mode = 1'b0;
      in_single = 4'h0;
      $display("test dual done");
   endtask

   initial begin
      wait_cyc(15);
      check(gate_on, 4'h0);
      check({3'h0, fault_n}, 4'h1);
      wait_cyc(1);
      resetn = 1'b1;
      wait_cyc(10);
      t_follow();
      t_blank();
      t_trip();
      t_open();
      t_dual();
      summarize();
   end

   // tests need about 465 us; the limit keeps a hang near 100k cycles
   initial begin
      #500000;
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire

// ==== logic/qsf_pkg.sv ====
package qsf_pkg;

   localparam int unsigned NCH = 4;

   // times as printed, in nanoseconds
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned OC_SENSE_NS    = 55000;
   localparam int unsigned REFRESH_NS     = 3600000;
   localparam int unsigned SOFT_OPEN_NS   = 2200000;
   localparam int unsigned ON_MASK_NS     = 20000;
   localparam int unsigned OFF_MASK_NS    = 19000;
   localparam int unsigned STAT_RESET_NS  = 20000;

   // single time base: one tick per microsecond
   localparam int unsigned TICK_NS        = 1000;
   localparam int unsigned TICK_CYC       = TICK_NS / CLK_PERIOD_NS;

   // delays as counts of time-base ticks
   localparam int unsigned OC_SENSE_TK    = OC_SENSE_NS / TICK_NS;
   localparam int unsigned REFRESH_TK     = REFRESH_NS / TICK_NS;
   localparam int unsigned SOFT_OPEN_TK   = SOFT_OPEN_NS / TICK_NS;
   localparam int unsigned ON_MASK_TK     = ON_MASK_NS / TICK_NS;
   localparam int unsigned OFF_MASK_TK    = OFF_MASK_NS / TICK_NS;
   localparam int unsigned STAT_RESET_TK  = STAT_RESET_NS / TICK_NS;

   localparam int unsigned TKW            = 12;
   localparam int unsigned PREW           = 8;
   localparam int unsigned SYNC_STAGES    = 3;

   typedef struct packed {
      logic [NCH-1:0] oc_detect;
      logic [NCH-1:0] on_open;
      logic [NCH-1:0] off_open;
   } qsf_sense_t;

   typedef enum logic [1:0] {
      QSF_OFF,
      QSF_SENSE,
      QSF_RETRY_WAIT
   } qsf_ch_state_t;

endpackage

// ==== logic/qsf_supervisor.sv ====
// Functional notes
// - over-current only while input high and comparator
// - hold report for sense time; cleared means none
// - persisting over-current: fault low, channel off
// - per-channel sense timer restarts on each turn-on
// - report restarts shared refresh timer, holds off
// - refresh expiry turns faulted channels back on
// - retry repeats until input low or cleared
// - all inputs low releases over-current after delay
// - off open-load reported only with inputs low
// - located over-current re-reports after sense time
// - on open-load keeps fault after on-mask
// - soft open reported like over-current, longer delay
// - shared on-mask timer restarts on any rise
// - per-channel off-mask timer restarts on fall
`timescale 1ns/1ps
`default_nettype none
module qsf_supervisor
   import qsf_pkg::*;
(
   input  wire logic           sys_clk,
   input  wire logic           resetn,
   input  wire logic [NCH-1:0] in_single,
   input  wire logic [1:0]     in_pair,
   input  wire logic           dual_mode,
   input  wire qsf_sense_t     sense,
   output logic      [NCH-1:0] gate_on,
   output logic                fault_n
);
   logic [NCH+2+1-1:0] raw_in;
   logic [NCH+2+1-1:0] syn_in;
   logic [NCH-1:0]     ch_in;
   logic [NCH-1:0]     ch_in_q;
   logic [NCH-1:0]     rise;
   logic [NCH-1:0]     fall;
   logic               any_in;
   logic [PREW-1:0]    pre_q;
   logic               tick;
   logic [TKW-1:0]     onmask_q;
   logic               onmask_done;
   logic [TKW-1:0]     ref_q;
   logic               ref_run_q;
   logic               ref_expire;
   logic [TKW-1:0]     rst_q;
   logic               oc_rep_q;
   logic [NCH-1:0]     oc_trip;
   logic [NCH-1:0]     off_open_rep;
   logic [NCH-1:0]     soft_rep;
   logic [NCH-1:0]     on_open_rep;
   logic [NCH-1:0]     held_off;
   logic               report_new;

   // host pins are asynchronous; sense already runs on this clock
   assign raw_in = {dual_mode, in_pair, in_single};

   qsf_sync #(
      .W(NCH+3)
   ) u_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .async_in (raw_in),
      .sync_out (syn_in)
   );

   // paired mode: pair input drives both channels of the pair
   always_comb begin
      if (syn_in[NCH+2]) begin
         ch_in = {{2{syn_in[NCH+1]}}, {2{syn_in[NCH]}}};
      end else begin
         ch_in = syn_in[NCH-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch_in_q <= '0;
      end else begin
         ch_in_q <= ch_in;
      end
   end

   assign rise   = ch_in & ~ch_in_q;
   assign fall   = ~ch_in & ch_in_q;
   assign any_in = |ch_in;

   // one time base for every delay, kept small in flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= '0;
      end else if (pre_q == PREW'(TICK_CYC - 1)) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PREW'(1);
      end
   end
   assign tick = (pre_q == PREW'(TICK_CYC - 1));

   // shared on-mask timer, restarted by any rising input
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         onmask_q <= '0;
      end else if (|rise) begin
         onmask_q <= '0;
      end else if (tick && !onmask_done) begin
         onmask_q <= onmask_q + TKW'(1);
      end
   end
   assign onmask_done = (onmask_q >= TKW'(ON_MASK_TK));

   // shared refresh timer
   assign report_new = |oc_trip;
   assign ref_expire = ref_run_q && tick && (ref_q == TKW'(REFRESH_TK - 1));

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ref_q     <= '0;
         ref_run_q <= 1'b0;
      end else if (report_new) begin
         ref_q     <= '0;
         ref_run_q <= 1'b1;
      end else if (ref_expire) begin
         ref_q     <= '0;
         ref_run_q <= 1'b0;
      end else if (ref_run_q && tick) begin
         ref_q <= ref_q + TKW'(1);
      end
   end

   // per-channel sense, soft-open and off-mask timers
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [TKW-1:0] oc_q;
      logic [TKW-1:0] soft_q;
      logic [TKW-1:0] offm_q;
      logic           hold_q;
      logic           turn_on;
      logic           det;

      // channel comes on from its input or from refresh expiry
      assign turn_on = (rise[c] && !hold_q) ||
                       (ref_expire && hold_q && ch_in[c]);
      assign det = ch_in[c] && !hold_q &&
                   sense.oc_detect[c];
      assign oc_trip[c] = det && tick &&
                          (oc_q == TKW'(OC_SENSE_TK - 1));

      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            oc_q <= '0;
         end else if (turn_on) begin
            oc_q <= '0;
         end else if (!det) begin
            oc_q <= '0;
         end else if (tick && oc_q < TKW'(OC_SENSE_TK)) begin
            oc_q <= oc_q + TKW'(1);
         end
      end

      // held off from trip to refresh expiry, dropped when input low
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            hold_q <= 1'b0;
         end else if (!ch_in[c]) begin
            hold_q <= 1'b0;
         end else if (oc_trip[c]) begin
            hold_q <= 1'b1;
         end else if (ref_expire) begin
            hold_q <= 1'b0;
         end
      end
      assign held_off[c] = hold_q;

      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            soft_q <= '0;
         end else if (!ch_in[c] || !sense.on_open[c]) begin
            soft_q <= '0;
         end else if (tick && soft_q < TKW'(SOFT_OPEN_TK)) begin
            soft_q <= soft_q + TKW'(1);
         end
      end
      // soft open: seen on, not off, reported after the long delay
      assign soft_rep[c] = ch_in[c] && sense.on_open[c] &&
                           !sense.off_open[c] &&
                           soft_q >= TKW'(SOFT_OPEN_TK);
      assign on_open_rep[c] = ch_in[c] && sense.on_open[c] &&
                              sense.off_open[c] &&
                              onmask_done;

      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            offm_q <= '0;
         end else if (fall[c]) begin
            offm_q <= '0;
         end else if (tick && offm_q < TKW'(OFF_MASK_TK)) begin
            offm_q <= offm_q + TKW'(1);
         end
      end
      assign off_open_rep[c] = !any_in && sense.off_open[c] &&
                               offm_q >= TKW'(OFF_MASK_TK);

      assign gate_on[c] = ch_in[c] && !hold_q;
   end

   // over-current report: latched at trip, released with inputs low
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_q <= '0;
      end else if (any_in) begin
         rst_q <= '0;
      end else if (tick && rst_q < TKW'(STAT_RESET_TK)) begin
         rst_q <= rst_q + TKW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         oc_rep_q <= 1'b0;
      end else if (report_new) begin
         oc_rep_q <= 1'b1;
      end else if (!any_in && rst_q >= TKW'(STAT_RESET_TK)) begin
         oc_rep_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fault_n <= 1'b1;
      end else begin
         fault_n <= !(oc_rep_q || (|soft_rep) || (|on_open_rep) ||
                      (|off_open_rep) || report_new);
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   trip_holds_off_a: assert property (oc_trip != '0 |=>
      (gate_on & $past(oc_trip)) == '0)
      else $error("channel on after trip");
   trip_reports_a: assert property (report_new |=> !fault_n)
      else $error("fault not reported after trip");
   trip_needs_input_a: assert property (|oc_trip |-> |ch_in)
      else $error("trip with no input high");
   off_open_quiet_a: assert property (any_in |-> off_open_rep == '0)
      else $error("off open-load with input high");
   ref_starts_a: assert property (
      report_new |=> ref_run_q && ref_q == '0)
      else $error("refresh timer not restarted");
   rise_clears_mask_a: assert property (|rise |=> onmask_q == '0)
      else $error("on-mask timer not restarted");
   fall_clears_off_a: assert property (
      fall[1] |=> g_ch[1].offm_q == '0)
      else $error("off-mask timer not restarted");
   expire_releases_a: assert property (ref_expire |=> !ref_run_q)
      else $error("refresh did not end");
   tick_period_a: assert property (tick |=> !tick [*8])
      else $error("time base too fast");

   trip_seen_c: cover property (report_new);
   retry_seen_c: cover property (ref_expire);
   release_seen_c: cover property ($rose(fault_n));
endmodule
`default_nettype wire

// ==== logic/qsf_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsf_sync
   import qsf_pkg::*;
#(
   parameter int unsigned W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // first stage is read only by the second
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_out <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               sync_out[i] <= s3_q[i];
            end
         end
      end
   end
endmodule
`default_nettype wire
